// >>> src/idt_pkg.sv
// Package for the instruction decode and cycle-count block
package idt_pkg;

    // ------------------------------------------------------------
    // Operation classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IDT_OP_NOP,
        IDT_OP_ARITH,
        IDT_OP_LOGIC,
        IDT_OP_ROTATE,
        IDT_OP_MOVE,
        IDT_OP_CODE_READ,
        IDT_OP_XDATA_READ,
        IDT_OP_XDATA_WRITE,
        IDT_OP_STACK,
        IDT_OP_EXCHANGE,
        IDT_OP_JUMP,
        IDT_OP_COND_JUMP,
        IDT_OP_CALL_RET,
        IDT_OP_BOOLEAN,
        IDT_OP_MULDIV,
        IDT_OP_INCDEC
    } idt_op_class_t;

    // ------------------------------------------------------------
    // Decode result
    // ------------------------------------------------------------
    typedef struct packed {
        idt_op_class_t op_class;
        logic [1:0] length;
        logic [2:0] cycles;
    } idt_decode_t;

    // Fetch stream byte
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } idt_fetch_t;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam logic [7:0] IDT_INTERFACE_CONTROL_REGISTER_ADDR = 8'h8F;
    localparam int IDT_ONE_CLK_BIT = 7;
    localparam logic [1:0] IDT_LEN_1 = 2'h1;
    localparam logic [1:0] IDT_LEN_2 = 2'h2;
    localparam logic [1:0] IDT_LEN_3 = 2'h3;
    localparam logic [2:0] IDT_CYC_1 = 3'h1;
    localparam logic [2:0] IDT_CYC_2 = 3'h2;
    localparam logic [2:0] IDT_CYC_3 = 3'h3;
    localparam logic [2:0] IDT_CYC_4 = 3'h4;
    localparam logic [2:0] IDT_CYC_5 = 3'h5;
    localparam logic [2:0] IDT_CYC_6 = 3'h6;
    localparam logic [2:0] IDT_CYC_MAX = 3'h6;

endpackage : idt_pkg

// >>> src/idt_decoder.sv
// Instruction decode and machine-cycle timing for the 8-bit core
// Notes on behaviour
// - standard opcode map, only cycle counts differ
// - 28-2F add register: one byte, one cycle
// - 38-3F, 98-9F: one byte, one cycle
// - indirect RAM arithmetic: one byte, two cycles
// - immediate arithmetic: two bytes, two cycles
// - 52/42/62: two bytes, three cycles
// - 53/43/63: three bytes, four cycles
// - rotates and swap: one byte, one cycle
// - A8-AF 2B/4 cycles; F8-FF 1B/2 cycles
// - A6-A7: two bytes, five cycles
// - 90: three bytes, three cycles
// - 93 and 83: one byte, three cycles
// - E0, E2-E3: one byte, three cycles
// - F0, F2-F3: one byte, four cycles
// - C0 2B/4 cycles; D0 2B/3 cycles
// - D6-D7: one byte, three cycles
// - 73: one byte, two cycles
// - 60/70/40/50: two bytes, three cycles
// - 20/30/10: three bytes, four cycles
// - compare-and-jump forms: three bytes, four cycles
// - D8-DF 2B/3 cycles; D5 3B/4 cycles
// - 82/B0/72/A0 two cycles; 92 three
// - two clocks per cycle; control bit 7 selects one
// - counts are machine cycles of mode clocks
`timescale 1ns/1ps
`default_nettype none

module idt_decoder (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Program memory fetch stream
    input wire idt_pkg::idt_fetch_t fetch_i,
    output logic fetch_ready_o,
    // Interface control register write from the datapath
    input wire logic interface_control_register_we_i,
    input wire logic [7:0] interface_control_register_addr_i,
    input wire logic [7:0] interface_control_register_wdata_i,
    // Decode result to the datapath
    output logic decode_valid_o,
    output idt_pkg::idt_decode_t decode_o,
    output logic [7:0] opcode_o,
    output logic mcycle_tick_o,
    output logic instr_done_o,
    output logic one_clk_mode_o
);
    import idt_pkg::*;

    // ------------------------------------------------------------
    // Opcode table
    // ------------------------------------------------------------
    function automatic idt_decode_t idt_lookup(input logic [7:0] op);
        idt_decode_t d;
        d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_1, cycles: IDT_CYC_1};
        if (op[3:0] == 4'h1) begin
            d = '{op_class: IDT_OP_JUMP, length: IDT_LEN_2, cycles: IDT_CYC_3};
            if (op[4]) begin
                d = '{op_class: IDT_OP_CALL_RET, length: IDT_LEN_2, cycles: IDT_CYC_6};
            end
        end else if (op[3]) begin
            // Working register forms
            unique case (op[7:4])
                4'h0, 4'h1: d = '{op_class: IDT_OP_INCDEC, length: IDT_LEN_1, cycles: IDT_CYC_2};
                4'h2, 4'h3, 4'h9: d = '{op_class: IDT_OP_ARITH, length: IDT_LEN_1,
                    cycles: IDT_CYC_1};
                4'h4, 4'h5, 4'h6: d = '{op_class: IDT_OP_LOGIC, length: IDT_LEN_1,
                    cycles: IDT_CYC_1};
                4'h7: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_2};
                4'h8: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_3};
                4'hA: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_4};
                4'hB: d = '{op_class: IDT_OP_COND_JUMP, length: IDT_LEN_3,
                    cycles: IDT_CYC_4};
                4'hC: d = '{op_class: IDT_OP_EXCHANGE, length: IDT_LEN_1, cycles: IDT_CYC_2};
                4'hD: d = '{op_class: IDT_OP_COND_JUMP, length: IDT_LEN_2,
                    cycles: IDT_CYC_3};
                4'hE: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_1, cycles: IDT_CYC_1};
                default: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_1,
                    cycles: IDT_CYC_2};
            endcase
        end else if (op[3:1] == 3'h3) begin
            // Indirect RAM forms
            unique case (op[7:4])
                4'h0, 4'h1: d = '{op_class: IDT_OP_INCDEC, length: IDT_LEN_1, cycles: IDT_CYC_3};
                4'h2, 4'h3, 4'h9: d = '{op_class: IDT_OP_ARITH, length: IDT_LEN_1,
                    cycles: IDT_CYC_2};
                4'h4, 4'h5, 4'h6: d = '{op_class: IDT_OP_LOGIC, length: IDT_LEN_1,
                    cycles: IDT_CYC_2};
                4'h7: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_3};
                4'h8: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_4};
                4'hA: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_5};
                4'hB: d = '{op_class: IDT_OP_COND_JUMP, length: IDT_LEN_3,
                    cycles: IDT_CYC_4};
                4'hC: d = '{op_class: IDT_OP_EXCHANGE, length: IDT_LEN_1, cycles: IDT_CYC_3};
                4'hD: d = '{op_class: IDT_OP_EXCHANGE, length: IDT_LEN_1,
                    cycles: IDT_CYC_3};
                4'hE: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_1, cycles: IDT_CYC_2};
                default: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_1, cycles: IDT_CYC_3};
            endcase
        end else begin
            unique case (op)
                8'h00: d = '{op_class: IDT_OP_NOP, length: IDT_LEN_1, cycles: IDT_CYC_1};
                8'h02: d = '{op_class: IDT_OP_JUMP, length: IDT_LEN_3, cycles: IDT_CYC_4};
                8'h12: d = '{op_class: IDT_OP_CALL_RET, length: IDT_LEN_3, cycles: IDT_CYC_6};
                8'h22, 8'h32: d = '{op_class: IDT_OP_CALL_RET, length: IDT_LEN_1,
                    cycles: IDT_CYC_4};
                8'h03, 8'h13, 8'h23, 8'h33, 8'hC4: d = '{op_class: IDT_OP_ROTATE,
                    length: IDT_LEN_1, cycles: IDT_CYC_1};
                8'h04, 8'h14, 8'hA3: d = '{op_class: IDT_OP_INCDEC, length: IDT_LEN_1,
                    cycles: IDT_CYC_1};
                8'h05, 8'h15: d = '{op_class: IDT_OP_INCDEC, length: IDT_LEN_2,
                    cycles: IDT_CYC_3};
                8'h24, 8'h34, 8'h94: d = '{op_class: IDT_OP_ARITH, length: IDT_LEN_2,
                    cycles: IDT_CYC_2};
                8'h25, 8'h35, 8'h95: d = '{op_class: IDT_OP_ARITH, length: IDT_LEN_2,
                    cycles: IDT_CYC_2};
                8'h42, 8'h52, 8'h62: d = '{op_class: IDT_OP_LOGIC, length: IDT_LEN_2,
                    cycles: IDT_CYC_3};
                8'h43, 8'h53, 8'h63: d = '{op_class: IDT_OP_LOGIC, length: IDT_LEN_3,
                    cycles: IDT_CYC_4};
                8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65: d = '{op_class: IDT_OP_LOGIC,
                    length: IDT_LEN_2, cycles: IDT_CYC_2};
                8'hE4, 8'hF4: d = '{op_class: IDT_OP_LOGIC, length: IDT_LEN_1,
                    cycles: IDT_CYC_1};
                8'hD4: d = '{op_class: IDT_OP_ARITH, length: IDT_LEN_1, cycles: IDT_CYC_1};
                8'hA4, 8'h84: d = '{op_class: IDT_OP_MULDIV, length: IDT_LEN_1,
                    cycles: IDT_CYC_5};
                8'h74, 8'hE5: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_2};
                8'hF5: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_2, cycles: IDT_CYC_3};
                8'h85: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_3, cycles: IDT_CYC_4};
                8'h75: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_3, cycles: IDT_CYC_3};
                8'h90: d = '{op_class: IDT_OP_MOVE, length: IDT_LEN_3, cycles: IDT_CYC_3};
                8'h93, 8'h83: d = '{op_class: IDT_OP_CODE_READ, length: IDT_LEN_1,
                    cycles: IDT_CYC_3};
                8'hE0, 8'hE2, 8'hE3: d = '{op_class: IDT_OP_XDATA_READ, length: IDT_LEN_1,
                    cycles: IDT_CYC_3};
                8'hF0, 8'hF2, 8'hF3: d = '{op_class: IDT_OP_XDATA_WRITE, length: IDT_LEN_1,
                    cycles: IDT_CYC_4};
                8'hC0: d = '{op_class: IDT_OP_STACK, length: IDT_LEN_2, cycles: IDT_CYC_4};
                8'hD0: d = '{op_class: IDT_OP_STACK, length: IDT_LEN_2, cycles: IDT_CYC_3};
                8'hC5: d = '{op_class: IDT_OP_EXCHANGE, length: IDT_LEN_2, cycles: IDT_CYC_3};
                8'h73: d = '{op_class: IDT_OP_JUMP, length: IDT_LEN_1, cycles: IDT_CYC_2};
                8'h80: d = '{op_class: IDT_OP_JUMP, length: IDT_LEN_2, cycles: IDT_CYC_3};
                8'h40, 8'h50, 8'h60, 8'h70: d = '{op_class: IDT_OP_COND_JUMP,
                    length: IDT_LEN_2, cycles: IDT_CYC_3};
                8'h10, 8'h20, 8'h30: d = '{op_class: IDT_OP_COND_JUMP, length: IDT_LEN_3,
                    cycles: IDT_CYC_4};
                8'hB4, 8'hB5, 8'hD5: d = '{op_class: IDT_OP_COND_JUMP, length: IDT_LEN_3,
                    cycles: IDT_CYC_4};
                8'hC3, 8'hD3, 8'hB3: d = '{op_class: IDT_OP_BOOLEAN, length: IDT_LEN_1,
                    cycles: IDT_CYC_1};
                8'hC2, 8'hD2, 8'hB2, 8'h92: d = '{op_class: IDT_OP_BOOLEAN,
                    length: IDT_LEN_2, cycles: IDT_CYC_3};
                8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: d = '{op_class: IDT_OP_BOOLEAN,
                    length: IDT_LEN_2, cycles: IDT_CYC_2};
                default: d = '{op_class: IDT_OP_NOP, length: IDT_LEN_1, cycles: IDT_CYC_1};
            endcase
        end
        return d;
    endfunction : idt_lookup

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDT_ST_OPCODE,
        IDT_ST_OPERAND,
        IDT_ST_EXECUTE
    } idt_state_t;

    idt_state_t state;
    idt_state_t next_state;
    idt_decode_t cur;
    idt_decode_t next_cur;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic [1:0] bytes_got;
    logic [1:0] next_bytes_got;
    logic [2:0] cyc_done;
    logic [2:0] next_cyc_done;
    logic phase;
    logic next_phase;
    logic one_clk;
    logic next_one_clk;
    logic dec_valid;
    logic next_dec_valid;
    logic done;
    logic next_done;
    logic tick;
    logic next_tick;
    logic ready;
    logic next_ready;
    logic tick_now;
    logic take;

    always_comb begin
        tick_now = one_clk | phase;
        take = fetch_i.valid & ready;
        next_phase = one_clk ? 1'b0 : ~phase;
        next_one_clk = one_clk;
        if (interface_control_register_we_i && interface_control_register_addr_i == IDT_INTERFACE_CONTROL_REGISTER_ADDR) begin
            next_one_clk = interface_control_register_wdata_i[IDT_ONE_CLK_BIT];
        end
        next_state = state;
        next_cur = cur;
        next_opcode = opcode;
        next_bytes_got = bytes_got;
        next_cyc_done = cyc_done;
        next_dec_valid = 1'b0;
        next_done = 1'b0;
        next_tick = tick_now;
        next_ready = ready;
        case (state)
            IDT_ST_OPCODE: begin
                next_cyc_done = '0;
                next_ready = 1'b1;
                if (take) begin
                    next_cur = idt_lookup(fetch_i.data);
                    next_opcode = fetch_i.data;
                    next_bytes_got = IDT_LEN_1;
                    next_dec_valid = 1'b1;
                    if (next_cur.length == IDT_LEN_1) begin
                        next_state = IDT_ST_EXECUTE;
                        next_ready = 1'b0;
                    end else begin
                        next_state = IDT_ST_OPERAND;
                    end
                    if (tick_now) begin
                        next_cyc_done = 3'h1;
                    end
                end
            end
            IDT_ST_OPERAND: begin
                if (tick_now && cyc_done != IDT_CYC_MAX) begin
                    next_cyc_done = cyc_done + 3'h1;
                end
                if (take) begin
                    next_bytes_got = bytes_got + 2'h1;
                    if (next_bytes_got == cur.length) begin
                        next_state = IDT_ST_EXECUTE;
                        next_ready = 1'b0;
                    end
                end
            end
            IDT_ST_EXECUTE: begin
                next_ready = 1'b0;
                if (tick_now) begin
                    next_cyc_done = cyc_done + 3'h1;
                end
                if (next_cyc_done >= cur.cycles) begin
                    next_state = IDT_ST_OPCODE;
                    next_done = 1'b1;
                    next_ready = 1'b1;
                end
            end
            default: begin
                next_state = IDT_ST_OPCODE;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= IDT_ST_OPCODE;
            cur <= '{op_class: IDT_OP_NOP, length: IDT_LEN_1, cycles: IDT_CYC_1};
            opcode <= '0;
            bytes_got <= '0;
            cyc_done <= '0;
            phase <= 1'b0;
            one_clk <= 1'b0;
            dec_valid <= 1'b0;
            done <= 1'b0;
            tick <= 1'b0;
            ready <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            opcode <= next_opcode;
            bytes_got <= next_bytes_got;
            cyc_done <= next_cyc_done;
            phase <= next_phase;
            one_clk <= next_one_clk;
            dec_valid <= next_dec_valid;
            done <= next_done;
            tick <= next_tick;
            ready <= next_ready;
        end
    end

    assign fetch_ready_o = ready;
    assign decode_valid_o = dec_valid;
    assign decode_o = cur;
    assign opcode_o = opcode;
    assign mcycle_tick_o = tick;
    assign instr_done_o = done;
    assign one_clk_mode_o = one_clk;

endmodule : idt_decoder

`default_nettype wire

// >>> dv/idt_decoder_assertions.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none

module idt_decoder_assertions (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Fetch stream
    input wire idt_pkg::idt_fetch_t fetch_i,
    input wire logic fetch_ready_o,
    // Mode write
    input wire logic interface_control_register_we_i,
    input wire logic [7:0] interface_control_register_addr_i,
    input wire logic [7:0] interface_control_register_wdata_i,
    // Decode result
    input wire logic decode_valid_o,
    input wire idt_pkg::idt_decode_t decode_o,
    input wire logic [7:0] opcode_o,
    input wire logic mcycle_tick_o,
    input wire logic instr_done_o,
    input wire logic one_clk_mode_o
);
    import idt_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------
    // Clocks and operand bytes since the last decode
    // ------------------------------------------------------------
    logic [5:0] clks, next_clks;
    logic [1:0] got, next_got;
    logic [4:0] need;
    // Take edge may fall on a tick, so two-clock mode can finish one clock early
    assign need = one_clk_mode_o ? {2'h0, decode_o.cycles} : {1'h0, decode_o.cycles, 1'h0} - 5'h01;
    always_comb begin
        next_clks = decode_valid_o ? 6'h01 : clks + {5'h00, clks != 6'h3E};
        next_got = (decode_valid_o ? 2'h0 : got) + {1'h0, fetch_i.valid & fetch_ready_o};
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clks <= 6'h00;
            got <= 2'h0;
        end else begin
            clks <= next_clks;
            got <= next_got;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_take;
        fetch_i.valid && fetch_ready_o;
    endsequence
    sequence s_mode_wr;
        interface_control_register_we_i && interface_control_register_addr_i == IDT_INTERFACE_CONTROL_REGISTER_ADDR;
    endsequence
    property p_lc(logic hit, logic [1:0] l, logic [2:0] c);
        decode_valid_o && hit |-> decode_o.length == l && decode_o.cycles == c;
    endproperty
    a_decode_cause: assert property (decode_valid_o |-> $past(fetch_i.valid && fetch_ready_o) && opcode_o == $past(fetch_i.data))
        else $error("decode without a taken opcode");
    a_add_reg: assert property (p_lc(opcode_o inside {[8'h28:8'h2F]}, IDT_LEN_1, IDT_CYC_1))
        else $error("register add length or cycles wrong");
    a_imm_arith: assert property (p_lc(opcode_o inside {8'h24, 8'h34, 8'h94}, IDT_LEN_2, IDT_CYC_2))
        else $error("immediate arithmetic length or cycles wrong");
    a_logic_imm: assert property (p_lc(opcode_o inside {8'h53, 8'h43, 8'h63}, IDT_LEN_3, IDT_CYC_4))
        else $error("immediate logic to direct length or cycles wrong");
    a_ind_move: assert property (p_lc(opcode_o inside {8'hA6, 8'hA7}, IDT_LEN_2, IDT_CYC_5))
        else $error("direct to indirect move length or cycles wrong");
    a_ptr_load: assert property (p_lc(opcode_o == 8'h90, IDT_LEN_3, IDT_CYC_3))
        else $error("pointer load length or cycles wrong");
    a_xdata_wr: assert property (p_lc(opcode_o inside {8'hF0, 8'hF2, 8'hF3}, IDT_LEN_1, IDT_CYC_4))
        else $error("external write length or cycles wrong");
    a_mode_write: assert property (s_mode_wr |=> one_clk_mode_o == $past(interface_control_register_wdata_i[7]))
        else $error("mode not taken from control write");
    a_mode_hold: assert property (!(interface_control_register_we_i && interface_control_register_addr_i == IDT_INTERFACE_CONTROL_REGISTER_ADDR) |=> $stable(one_clk_mode_o))
        else $error("mode changed without control write");
    a_decode_hold: assert property (!decode_valid_o |-> $stable(decode_o))
        else $error("decode result changed between opcodes");
    a_done_bytes: assert property (instr_done_o |-> got == decode_o.length - 2'h1)
        else $error("instruction done before all bytes taken");
    a_done_time: assert property (instr_done_o |-> clks + 6'h01 >= 6'(need))
        else $error("instruction done before its machine cycles");
    a_done_bound: assert property (s_take ##1 decode_valid_o |-> ##[1:60] instr_done_o)
        else $error("instruction never completed");
endmodule : idt_decoder_assertions

bind idt_decoder idt_decoder_assertions u_idt_decoder_assertions (
    .mclk_i, .rstn_i, .fetch_i, .fetch_ready_o, .interface_control_register_we_i, .interface_control_register_addr_i, .interface_control_register_wdata_i,
    .decode_valid_o, .decode_o, .opcode_o, .mcycle_tick_o, .instr_done_o, .one_clk_mode_o
);
`default_nettype wire

// >>> dv/idt_fetch_model.sv
// Program memory fetch stream model feeding the decoder
`timescale 1ns/1ps
`default_nettype none

module idt_fetch_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Flow control
    input wire logic stall_i,
    input wire logic fetch_ready_i,
    // Byte stream
    output var idt_pkg::idt_fetch_t fetch_o
);
    import idt_pkg::*;
    logic [7:0] q[$];
    // Byte held until taken; idle data toggles so stale values never match
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_o <= '0;
        end else if (!fetch_o.valid || fetch_ready_i) begin
            if (fetch_o.valid) begin
                void'(q.pop_front());
            end
            if (q.size() > 0 && !stall_i) begin
                fetch_o <= '{valid: 1'b1, data: q[0]};
            end else begin
                fetch_o <= '{valid: 1'b0, data: ~fetch_o.data};
            end
        end
    end
endmodule : idt_fetch_model
`default_nettype wire

// >>> dv/test_cpu_instruction_decode_timing.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none

module test_cpu_instruction_decode_timing;
    import idt_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic stall = 1'b0;
    logic interface_control_register_we_i = 1'b0;
    logic [7:0] interface_control_register_addr_i = 8'h00;
    logic [7:0] interface_control_register_wdata_i = 8'h00;
    idt_fetch_t fetch_i;
    idt_decode_t decode_o;
    logic fetch_ready_o, decode_valid_o, mcycle_tick_o, instr_done_o, one_clk_mode_o;
    logic [7:0] opcode_o, exp_op;
    logic [4:0] e, e2;
    logic [7:0] opq[$];
    int error_cnt = 0;
    int checks = 0;
    int seed = 45;
    int cpm = 2;
    int t = 0;
    int t_dec, lo, hi, el, n;
    int ndone = 0;

    always #12.5 mclk_i = ~mclk_i;

    idt_decoder u_idt_decoder (
        .mclk_i, .rstn_i, .fetch_i, .fetch_ready_o, .interface_control_register_we_i, .interface_control_register_addr_i, .interface_control_register_wdata_i,
        .decode_valid_o, .decode_o, .opcode_o, .mcycle_tick_o, .instr_done_o, .one_clk_mode_o
    );
    idt_fetch_model u_idt_fetch_model (
        .mclk_i, .rstn_i, .stall_i(stall), .fetch_ready_i(fetch_ready_o), .fetch_o(fetch_i)
    );

    // ------------------------------------------------------------
    // Reference length and cycle table, {length, cycles}
    // ------------------------------------------------------------
    function automatic logic [4:0] exp_lc(input logic [7:0] op);
        case (op) inside
            [8'h28:8'h2F], [8'h38:8'h3F], [8'h98:8'h9F], 8'h00, 8'hA5: return 5'h09;
            8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: return 5'h09;
            8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, [8'hF8:8'hFF], 8'h73: return 5'h0A;
            8'h24, 8'h34, 8'h94, 8'h82, 8'hB0, 8'h72, 8'hA0: return 5'h12;
            8'h52, 8'h42, 8'h62, 8'hD0, 8'h60, 8'h70, 8'h40, 8'h50, 8'h92: return 5'h13;
            [8'hD8:8'hDF]: return 5'h13;
            8'h53, 8'h43, 8'h63, 8'h20, 8'h30, 8'h10, [8'hB4:8'hBF], 8'hD5: return 5'h1C;
            [8'hA8:8'hAF], 8'hC0: return 5'h14;
            8'hA6, 8'hA7: return 5'h15;
            8'h90: return 5'h1B;
            8'h93, 8'h83, 8'hE0, 8'hE2, 8'hE3, 8'hD6, 8'hD7: return 5'h0B;
            8'hF0, 8'hF2, 8'hF3: return 5'h0C;
            default: return 5'h00;
        endcase
    endfunction : exp_lc

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        interface_control_register_we_i <= 1'b1;
        interface_control_register_addr_i <= a;
        interface_control_register_wdata_i <= d;
        @(posedge mclk_i);
        interface_control_register_we_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr

    task automatic tally_and_finish;
        $display("mismatches %0d of %0d comparisons", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Result monitor against the reference table
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        stall <= ($random(seed) & 3) == 0;
        t = t + 1;
        if (decode_valid_o === 1'b1) begin
            exp_op = opq.pop_front();
            e = exp_lc(exp_op);
            check(opcode_o, exp_op);
            check(8'({decode_o.length, decode_o.cycles}), 8'(e));
            t_dec = t;
            lo = int'(e[2:0]) * cpm - cpm + 1;
            hi = int'(e[2:0]) * cpm + 8 * int'(e[4:3]) + 2;
        end
        if (instr_done_o === 1'b1) begin
            el = t - t_dec + 1;
            check(8'(el >= lo && el <= hi), 8'h01);
            ndone++;
        end
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        check(8'(one_clk_mode_o), 8'h00);
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                wr(8'h8E, 8'h80);
                check(8'(one_clk_mode_o), 8'h00);
                wr(IDT_INTERFACE_CONTROL_REGISTER_ADDR, 8'h80);
                check(8'(one_clk_mode_o), 8'h01);
                cpm = 1;
            end
            #1;
            n = ndone;
            for (int op = 0; op < 256; op++) begin
                e2 = exp_lc(8'(op));
                if (e2 != 5'h00) begin
                    opq.push_back(8'(op));
                    u_idt_fetch_model.q.push_back(8'(op));
                    for (int b = 1; b < int'(e2[4:3]); b++) begin
                        u_idt_fetch_model.q.push_back(8'($random(seed)));
                    end
                    n++;
                end
            end
            for (int k = 0; k < 20000 && ndone < n; k++) @(posedge mclk_i);
            check(8'(ndone == n), 8'h01);
        end
        wr(IDT_INTERFACE_CONTROL_REGISTER_ADDR, 8'h00);
        check(8'(one_clk_mode_o), 8'h00);
        tally_and_finish;
    end

    initial begin
        #(25 * 40000);
        error_cnt++;
        tally_and_finish;
    end
endmodule : test_cpu_instruction_decode_timing
`default_nettype wire
